// ===== ppm_pkg.sv
// Constants for the port pin mode and alternate output routing block
package ppm_pkg;
   // ************************************************************
   // Register bus and map
   // ************************************************************
   localparam int          ADDR_W               = 8;
   localparam int          DATA_W               = 8;
   localparam logic [7:0]  ADDR_P1_BIT4_MODE    = 8'ha3;
   localparam logic [7:0]  ADDR_P3_LOW_MODES    = 8'ha4;
   localparam logic [7:0]  ADDR_P3_HIGH_MODES   = 8'ha5;
   localparam logic [7:0]  ADDR_ALT_ROUTING     = 8'ha6;
   localparam logic [7:0]  ADDR_PWM2_CONTROL    = 8'ha7;

   // ************************************************************
   // Reset values and writable masks
   // ************************************************************
   localparam logic [1:0]  RST_P1_BIT4_MODE     = 2'h0;
   localparam logic [7:0]  RST_P3_LOW_MODES     = 8'h55;
   localparam logic [7:0]  RST_P3_HIGH_MODES    = 8'h00;
   localparam logic [7:0]  RST_ALT_ROUTING      = 8'h00;
   localparam logic [7:0]  RST_PWM2_CONTROL     = 8'h00;
   localparam logic [7:0]  MASK_ALT_ROUTING     = 8'hf1;
   localparam logic [7:0]  MASK_PWM2_CONTROL    = 8'h10;
   localparam logic [7:0]  RST_P1_PIN           = 8'hff;
   localparam logic [7:0]  RST_P3_PIN           = 8'hff;
   localparam logic [1:0]  MODE_ANALOG          = 2'h3;

   // ************************************************************
   // Field and pin positions
   // ************************************************************
   localparam int          BIT_PWM1_OE          = 7;
   localparam int          BIT_PWM0_OE          = 6;
   localparam int          BIT_HALF_CLK_OE      = 5;
   localparam int          BIT_T2_OE            = 4;
   localparam int          BIT_T0_OE            = 0;
   localparam int          BIT_PWM2_OE          = 4;
   localparam int          PIN_PWM1             = 3;
   localparam int          PIN_PWM0             = 2;
   localparam int          PIN_HALF_CLK         = 4;
   localparam int          PIN_T2               = 0;
   localparam int          PIN_PWM2             = 6;
   localparam int          PIN_T0               = 4;

   // ************************************************************
   // Division ratios; a toggle stage flips every half ratio
   // ************************************************************
   localparam int          DIV_HALF_CLK         = 2;
   localparam int          DIV_T2               = 2;
   localparam int          DIV_T0               = 64;
endpackage

// ===== ppm_div_if.sv
// Interface between the routing logic and one toggle divider
`timescale 1ns/100ps
interface ppm_div_if;
   logic tick;
   logic enable;
   logic wave;

   // Routing side drives tick and enable, reads the wave
   modport ctrl (output tick, output enable, input wave);
   // Divider side
   modport div  (input tick, input enable, output wave);
endinterface

// ===== ppm_toggle_div.sv
// Toggle flip-flop divider: output flips once every HALF input ticks
`timescale 1ns/100ps
module ppm_toggle_div #(
   parameter int HALF = 1
) (
   input  wire logic sys_clk_i,
   input  wire logic reset_i,
   ppm_div_if.div    dv
);
   localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
   localparam logic [CW-1:0] LAST = CW'(HALF - 1);

   logic [CW-1:0] count;
   logic          wave;

   // Count ticks; disabling clears the stage so it restarts in phase
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         count <= '0;
         wave  <= 1'b0;
      end else if (!dv.enable) begin
         count <= '0;
         wave  <= 1'b0;
      end else if (dv.tick) begin
         if (count == LAST) begin
            count <= '0;
            wave  <= ~wave;
         end else begin
            count <= count + CW'(1);
         end
      end
   end

   assign dv.wave = wave;
endmodule

// ===== ppm_port_drive.sv
// Registered pin driver for one 8-bit port with alternate overrides
`timescale 1ns/100ps
module ppm_port_drive #(
   parameter logic [7:0] RESET_VAL = 8'hff
) (
   input  wire logic       sys_clk_i,
   input  wire logic       reset_i,
   input  wire logic [7:0] latch_i,
   input  wire logic [7:0] alt_en_i,
   input  wire logic [7:0] alt_val_i,
   output logic      [7:0] pin_o
);
   // Per bit: an enabled alternate source wins over the data latch
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         pin_o <= RESET_VAL;
      end else begin
         pin_o <= (alt_en_i & alt_val_i) | (~alt_en_i & latch_i);
      end
   end
endmodule

// ===== ppm_pin_route.sv
// Port 1/3 pin mode registers and alternate output routing
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
module ppm_pin_route
   import ppm_pkg::*;
(
   input  wire logic              sys_clk_i,
   input  wire logic              reset_i,
   // Register port
   input  wire logic [ADDR_W-1:0] reg_addr_i,
   input  wire logic [DATA_W-1:0] reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   output logic      [DATA_W-1:0] reg_rdata_o,
   // Port data latches
   input  wire logic [7:0]        p1_latch_i,
   input  wire logic [7:0]        p3_latch_i,
   // Internal sources
   input  wire logic              pwm0_wave_i,
   input  wire logic              pwm1_wave_i,
   input  wire logic              pwm2_wave_i,
   input  wire logic              timer2_ovf_i,
   input  wire logic              timer0_ovf_i,
   // Pins and controls
   output logic      [7:0]        p1_pin_o,
   output logic      [7:0]        p3_pin_o,
   output logic      [1:0]        p1_bit4_mode_o,
   output logic      [15:0]       p3_modes_o,
   output logic                   p1_bit4_analog_o,
   output logic      [3:0]        p3_analog_o,
   output logic                   pwm0_enable_o,
   output logic                   pwm1_enable_o,
   output logic                   pwm2_enable_o
);

   // ************************************************************
   // Register storage
   // ************************************************************
   logic [1:0] port1_bit4_mode;
   logic [7:0] port3_low_pin_modes;
   logic [7:0] port3_high_pin_modes;
   logic [7:0] alternate_output_routing;
   logic [7:0] pwm_channel2_control;

   logic       wr_p1_mode;
   logic       wr_p3_low;
   logic       wr_p3_high;
   logic       wr_alt;
   logic       wr_pwm2;

   // Write decode: one select per register, unmapped writes dropped
   always_comb begin
      wr_p1_mode = 1'b0;
      wr_p3_low  = 1'b0;
      wr_p3_high = 1'b0;
      wr_alt     = 1'b0;
      wr_pwm2    = 1'b0;
      if (!reg_wr_i) begin
         wr_p1_mode = 1'b0;
      end else if (reg_addr_i == ADDR_P1_BIT4_MODE) begin
         wr_p1_mode = 1'b1;
      end else if (reg_addr_i == ADDR_P3_LOW_MODES) begin
         wr_p3_low  = 1'b1;
      end else if (reg_addr_i == ADDR_P3_HIGH_MODES) begin
         wr_p3_high = 1'b1;
      end else if (reg_addr_i == ADDR_ALT_ROUTING) begin
         wr_alt     = 1'b1;
      end else if (reg_addr_i == ADDR_PWM2_CONTROL) begin
         wr_pwm2    = 1'b1;
      end
   end

   // Port1 bit4 mode field
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         port1_bit4_mode <= RST_P1_BIT4_MODE;
      end else if (wr_p1_mode) begin
         port1_bit4_mode <= reg_wdata_i[1:0];
      end
   end

   // Port3 low modes: every field comes up as Mode1
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         port3_low_pin_modes <= RST_P3_LOW_MODES;
      end else if (wr_p3_low) begin
         port3_low_pin_modes <= reg_wdata_i;
      end
   end

   // Port3 high modes: all four codes are digital modes
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         port3_high_pin_modes <= RST_P3_HIGH_MODES;
      end else if (wr_p3_high) begin
         port3_high_pin_modes <= reg_wdata_i;
      end
   end

   // Routing enables; unused bits are not stored and read zero
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         alternate_output_routing <= RST_ALT_ROUTING;
      end else if (wr_alt) begin
         alternate_output_routing <= reg_wdata_i & MASK_ALT_ROUTING;
      end
   end

   // PWM2 control: only the enable lives in this block
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         pwm_channel2_control <= RST_PWM2_CONTROL;
      end else if (wr_pwm2) begin
         pwm_channel2_control <= reg_wdata_i & MASK_PWM2_CONTROL;
      end
   end

   // ************************************************************
   // Read port
   // ************************************************************
   // Data stand only in the cycle after the strobe, zero otherwise
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         reg_rdata_o <= '0;
      end else if (!reg_rd_i) begin
         reg_rdata_o <= '0;
      end else if (reg_addr_i == ADDR_P1_BIT4_MODE) begin
         reg_rdata_o <= {6'h00, port1_bit4_mode};
      end else if (reg_addr_i == ADDR_P3_LOW_MODES) begin
         reg_rdata_o <= port3_low_pin_modes;
      end else if (reg_addr_i == ADDR_P3_HIGH_MODES) begin
         reg_rdata_o <= port3_high_pin_modes;
      end else if (reg_addr_i == ADDR_ALT_ROUTING) begin
         reg_rdata_o <= alternate_output_routing;
      end else if (reg_addr_i == ADDR_PWM2_CONTROL) begin
         reg_rdata_o <= pwm_channel2_control;
      end else begin
         reg_rdata_o <= '0;  // Unmapped reads return zero
      end
   end

   // ************************************************************
   // Mode outputs and analog selects
   // ************************************************************
   logic [1:0] port3_bit0_mode;
   logic [1:0] port3_bit1_mode;
   logic [1:0] port3_bit2_mode;
   logic [1:0] port3_bit3_mode;

   assign port3_bit0_mode = port3_low_pin_modes[1:0];
   assign port3_bit1_mode = port3_low_pin_modes[3:2];
   assign port3_bit2_mode = port3_low_pin_modes[5:4];
   assign port3_bit3_mode = port3_low_pin_modes[7:6];

   // Mode fields go straight out of their registers
   assign p1_bit4_mode_o = port1_bit4_mode;
   assign p3_modes_o     = {port3_high_pin_modes, port3_low_pin_modes};

   // Analog switch flags follow the mode fields one cycle later;
   // the lag keeps every output a flop and is harmless for an analog mux
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         p1_bit4_analog_o <= 1'b0;
      end else begin
         p1_bit4_analog_o <= (port1_bit4_mode == MODE_ANALOG);
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         p3_analog_o <= 4'h0;
      end else begin
         p3_analog_o[0] <= (port3_bit0_mode == MODE_ANALOG);
         p3_analog_o[1] <= (port3_bit1_mode == MODE_ANALOG);
         p3_analog_o[2] <= (port3_bit2_mode == MODE_ANALOG);
         p3_analog_o[3] <= (port3_bit3_mode == MODE_ANALOG);
      end
   end

   // ************************************************************
   // PWM channel enables
   // ************************************************************
   assign pwm1_enable_o = alternate_output_routing[BIT_PWM1_OE];
   assign pwm0_enable_o = alternate_output_routing[BIT_PWM0_OE];
   assign pwm2_enable_o = pwm_channel2_control[BIT_PWM2_OE];

   // ************************************************************
   // Dividers
   // ************************************************************
   ppm_div_if half_clk_dv ();
   ppm_div_if t2_dv ();
   ppm_div_if t0_dv ();

   // Each divider is held clear while its output is not routed,
   // so a fresh enable always starts from a low level
   assign half_clk_dv.tick   = 1'b1;
   assign half_clk_dv.enable = alternate_output_routing[BIT_HALF_CLK_OE];
   assign t2_dv.tick         = timer2_ovf_i;
   assign t2_dv.enable       = alternate_output_routing[BIT_T2_OE];
   assign t0_dv.tick         = timer0_ovf_i;
   assign t0_dv.enable       = alternate_output_routing[BIT_T0_OE];

   ppm_toggle_div #(.HALF(DIV_HALF_CLK / 2)) u_half_clk (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .dv        (half_clk_dv.div)
   );

   ppm_toggle_div #(.HALF(DIV_T2 / 2)) u_t2_div (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .dv        (t2_dv.div)
   );

   ppm_toggle_div #(.HALF(DIV_T0 / 2)) u_t0_div (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .dv        (t0_dv.div)
   );

   // ************************************************************
   // Pin override vectors
   // ************************************************************
   logic [7:0] p1_alt_en;
   logic [7:0] p1_alt_val;
   logic [7:0] p3_alt_en;
   logic [7:0] p3_alt_val;

   // Collect the routed sources by pin position
   always_comb begin
      p1_alt_en                = 8'h00;
      p1_alt_val               = 8'h00;
      p1_alt_en[PIN_PWM1]      = alternate_output_routing[BIT_PWM1_OE];
      p1_alt_val[PIN_PWM1]     = pwm1_wave_i;
      p1_alt_en[PIN_PWM0]      = alternate_output_routing[BIT_PWM0_OE];
      p1_alt_val[PIN_PWM0]     = pwm0_wave_i;
      p1_alt_en[PIN_HALF_CLK]  = alternate_output_routing[BIT_HALF_CLK_OE];
      p1_alt_val[PIN_HALF_CLK] = half_clk_dv.wave;
      p1_alt_en[PIN_T2]        = alternate_output_routing[BIT_T2_OE];
      p1_alt_val[PIN_T2]       = t2_dv.wave;
      p1_alt_en[PIN_PWM2]      = pwm_channel2_control[BIT_PWM2_OE];
      p1_alt_val[PIN_PWM2]     = pwm2_wave_i;
   end

   always_comb begin
      p3_alt_en            = 8'h00;
      p3_alt_val           = 8'h00;
      p3_alt_en[PIN_T0]    = alternate_output_routing[BIT_T0_OE];
      p3_alt_val[PIN_T0]   = t0_dv.wave;
   end

   ppm_port_drive #(.RESET_VAL(RST_P1_PIN)) u_p1_drive (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .latch_i   (p1_latch_i),
      .alt_en_i  (p1_alt_en),
      .alt_val_i (p1_alt_val),
      .pin_o     (p1_pin_o)
   );

   ppm_port_drive #(.RESET_VAL(RST_P3_PIN)) u_p3_drive (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .latch_i   (p3_latch_i),
      .alt_en_i  (p3_alt_en),
      .alt_val_i (p3_alt_val),
      .pin_o     (p3_pin_o)
   );

   // ************************************************************
   // Checks
   // ************************************************************
   chk_p1_analog_sel: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      wr_p1_mode && reg_wdata_i[1:0] == MODE_ANALOG |-> ##2 p1_bit4_analog_o)
      else $error("Port1 bit4 analog select missing");

   chk_p3_low_reset: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      $fell(reset_i) |-> port3_low_pin_modes == RST_P3_LOW_MODES)
      else $error("Port3 low modes not at Mode1 after reset");

   chk_p3_analog_sel: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      wr_p3_low |-> ##2 p3_analog_o[0] == ($past(reg_wdata_i[1:0], 2) == MODE_ANALOG)
                    && p3_analog_o[3] == ($past(reg_wdata_i[7:6], 2) == MODE_ANALOG))
      else $error("Port3 analog select does not follow mode write");

   chk_p3_high_write: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      wr_p3_high |=> p3_modes_o[15:8] == $past(reg_wdata_i))
      else $error("Port3 high modes write lost");

   chk_pwm1_route: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      alternate_output_routing[BIT_PWM1_OE] |=> p1_pin_o[PIN_PWM1] == $past(pwm1_wave_i))
      else $error("PWM1 wave not on its pin");

   chk_pwm0_route: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      alternate_output_routing[BIT_PWM0_OE] |=> p1_pin_o[PIN_PWM0] == $past(pwm0_wave_i))
      else $error("PWM0 wave not on its pin");

   chk_half_clk_toggle: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      alternate_output_routing[BIT_HALF_CLK_OE] [*2]
      |=> p1_pin_o[PIN_HALF_CLK] != $past(p1_pin_o[PIN_HALF_CLK]))
      else $error("Half clock output does not toggle every cycle");

   // The sampled reset keeps the release edge out: pins still hold their reset level there
   chk_half_clk_off: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      !reset_i && !alternate_output_routing[BIT_HALF_CLK_OE]
      |=> p1_pin_o[PIN_HALF_CLK] == $past(p1_latch_i[PIN_HALF_CLK]))
      else $error("Port1 bit4 not back on latch when routing off");

   chk_t2_half: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      alternate_output_routing[BIT_T2_OE] [*2] ##0 $past(timer2_ovf_i)
      |=> p1_pin_o[PIN_T2] != $past(p1_pin_o[PIN_T2]))
      else $error("Timer2 output does not toggle on overflow");

   chk_t0_off: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      !reset_i && !alternate_output_routing[BIT_T0_OE]
      |=> p3_pin_o[PIN_T0] == $past(p3_latch_i[PIN_T0]) && !t0_dv.wave)
      else $error("Port3 bit4 not on latch when Timer0 output off");

   chk_pwm2_route: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      pwm_channel2_control[BIT_PWM2_OE] |=> p1_pin_o[PIN_PWM2] == $past(pwm2_wave_i))
      else $error("PWM2 wave not on its pin");

   chk_read_routing: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      reg_rd_i && reg_addr_i == ADDR_ALT_ROUTING
      |=> reg_rdata_o == $past(alternate_output_routing))
      else $error("Routing register read returns wrong data");

   chk_p1_mode_write: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      wr_p1_mode |=> p1_bit4_mode_o == $past(reg_wdata_i[1:0]))
      else $error("Port1 bit4 mode write lost");

   // Read data must fall back to zero so a stale value is never mistaken
   chk_read_idle: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      !reg_rd_i |=> reg_rdata_o == '0)
      else $error("Read data not zero outside read cycle");
endmodule

// ===== tb_top.sv
// Self-checking testbench for the port pin mode and output routing block
`timescale 1ns/100ps
module tb_top
   import ppm_pkg::*;
;
   // ****************
   // Signals and clock
   // ****************
   logic        sys_clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic [7:0]  reg_addr_i = 8'h00;
   logic [7:0]  reg_wdata_i = 8'h00;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [7:0]  p1_latch_i = 8'h00;
   logic [7:0]  p3_latch_i = 8'h00;
   logic        pwm0_wave_i = 1'b0;
   logic        pwm1_wave_i = 1'b0;
   logic        pwm2_wave_i = 1'b0;
   logic        timer2_ovf_i = 1'b0;
   logic        timer0_ovf_i = 1'b0;
   logic [7:0]  reg_rdata_o;
   logic [7:0]  p1_pin_o;
   logic [7:0]  p3_pin_o;
   logic [1:0]  p1_bit4_mode_o;
   logic [15:0] p3_modes_o;
   logic        p1_bit4_analog_o;
   logic [3:0]  p3_analog_o;
   logic        pwm0_enable_o;
   logic        pwm1_enable_o;
   logic        pwm2_enable_o;
   int          failures = 0;
   int          checks_done = 0;
   logic [7:0]  sh [0:4];
   logic [7:0]  m_alt = 8'h00;
   logic [7:0]  m_pwm2 = 8'h00;
   logic [7:0]  m_prev = 8'h00;
   logic [7:0]  e1, e3, k1, k3, a, d;
   logic        prev;
   int          armed = 0;

   always #20 sys_clk_i = ~sys_clk_i;

   ppm_pin_route dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .p1_latch_i(p1_latch_i), .p3_latch_i(p3_latch_i),
      .pwm0_wave_i(pwm0_wave_i), .pwm1_wave_i(pwm1_wave_i), .pwm2_wave_i(pwm2_wave_i),
      .timer2_ovf_i(timer2_ovf_i), .timer0_ovf_i(timer0_ovf_i), .p1_pin_o(p1_pin_o),
      .p3_pin_o(p3_pin_o), .p1_bit4_mode_o(p1_bit4_mode_o), .p3_modes_o(p3_modes_o),
      .p1_bit4_analog_o(p1_bit4_analog_o), .p3_analog_o(p3_analog_o),
      .pwm0_enable_o(pwm0_enable_o), .pwm1_enable_o(pwm1_enable_o),
      .pwm2_enable_o(pwm2_enable_o));

   // Latches and waveforms wander every cycle so the override is always visible
   always @(posedge sys_clk_i) begin
      p1_latch_i  <= 8'($urandom);
      p3_latch_i  <= 8'($urandom);
      pwm0_wave_i <= 1'($urandom);
      pwm1_wave_i <= 1'($urandom);
      pwm2_wave_i <= 1'($urandom);
   end

   // ****************
   // Expectations and tasks
   // ****************
   function automatic logic [7:0] rmask(input logic [7:0] ad);
      case (ad)
         ADDR_P1_BIT4_MODE:                   return 8'h03;
         ADDR_P3_LOW_MODES, ADDR_P3_HIGH_MODES: return 8'hff;
         ADDR_ALT_ROUTING:                    return MASK_ALT_ROUTING;
         ADDR_PWM2_CONTROL:                   return MASK_PWM2_CONTROL;
         default:                             return 8'h00;
      endcase
   endfunction

   function automatic logic [3:0] analog4(input logic [7:0] m);
      logic [3:0] r;
      for (int k = 0; k < 4; k++) r[k] = (m[2*k+:2] == 2'h3);
      return r;
   endfunction

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      @(posedge sys_clk_i);
      reg_wr_i    <= 1'b1;
      reg_rd_i    <= 1'b0;
      reg_addr_i  <= ad;
      reg_wdata_i <= dt;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
      if (rmask(ad) != 8'h00) sh[ad-ADDR_P1_BIT4_MODE] = dt & rmask(ad);
   endtask

   // Read data stand one cycle only, then the port returns to zero
   task automatic rdchk(input logic [7:0] ad);
      logic [7:0] e;
      e = (rmask(ad) != 8'h00) ? sh[ad-ADDR_P1_BIT4_MODE] : 8'h00;
      @(posedge sys_clk_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= ad;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      @(negedge sys_clk_i);
      chk("read_data", {8'h00, e}, {8'h00, reg_rdata_o});
      @(negedge sys_clk_i);
      chk("read_idle", 16'h0000, {8'h00, reg_rdata_o});
   endtask

   // Analog flags lag the mode registers by one cycle, hence two edges
   task automatic chk_state();
      repeat (2) @(negedge sys_clk_i);
      chk("p3_modes", {sh[2], sh[1]}, p3_modes_o);
      chk("p1_b4_mode", {14'h0, sh[0][1:0]}, {14'h0, p1_bit4_mode_o});
      chk("p3_analog", {12'h0, analog4(sh[1])}, {12'h0, p3_analog_o});
      chk("p1_analog", {15'h0, sh[0][1:0] == 2'h3}, {15'h0, p1_bit4_analog_o});
      chk("pwm_en", {13'h0, sh[4][4], sh[3][7:6]},
          {13'h0, pwm2_enable_o, pwm1_enable_o, pwm0_enable_o});
   endtask

   task automatic do_reset();
      @(posedge sys_clk_i);
      reset_i <= 1'b1;
      @(negedge sys_clk_i);
      chk("reset_pins", {RST_P1_PIN, RST_P3_PIN}, {p1_pin_o, p3_pin_o});
      chk("reset_modes", 16'h0055, p3_modes_o);
      @(posedge sys_clk_i);
      reset_i <= 1'b0;
      sh = '{8'h00, 8'h55, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 6; i++) rdchk(ADDR_P1_BIT4_MODE + 8'(i));
      chk_state();
   endtask

   task automatic pulses(input int n, input bit t0);
      repeat (n) begin
         @(posedge sys_clk_i);
         if (t0) timer0_ovf_i <= 1'b1;
         else timer2_ovf_i <= 1'b1;
         @(posedge sys_clk_i);
         timer0_ovf_i <= 1'b0;
         timer2_ovf_i <= 1'b0;
      end
      repeat (3) @(negedge sys_clk_i);
   endtask

   task automatic final_report();
      if (failures == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Pin monitor; divided pins are skipped while routed and for one cycle after their enable clears
   always begin
      @(posedge sys_clk_i);
      e1 = p1_latch_i;
      if (m_alt[7]) e1[3] = pwm1_wave_i;
      if (m_alt[6]) e1[2] = pwm0_wave_i;
      if (m_pwm2[4]) e1[6] = pwm2_wave_i;
      e3 = p3_latch_i;
      k1 = {3'h7, ~(m_alt[5] | m_prev[5]), 3'h7, ~(m_alt[4] | m_prev[4])};
      k3 = {3'h7, ~(m_alt[0] | m_prev[0]), 4'hf};
      m_prev = m_alt;
      if (reset_i) begin
         m_alt  = 8'h00;
         m_pwm2 = 8'h00;
         armed  = 0;
      end else begin
         if (reg_wr_i && reg_addr_i == ADDR_ALT_ROUTING) m_alt = reg_wdata_i & MASK_ALT_ROUTING;
         if (reg_wr_i && reg_addr_i == ADDR_PWM2_CONTROL) m_pwm2 = reg_wdata_i & MASK_PWM2_CONTROL;
         if (armed < 2) armed++;
      end
      @(negedge sys_clk_i);
      if (armed == 2 && !reset_i) begin
         chk("p1_pins", {8'h00, e1 & k1}, {8'h00, p1_pin_o & k1});
         chk("p3_pins", {8'h00, e3 & k3}, {8'h00, p3_pin_o & k3});
      end
   end

   initial begin
      #(40 * 20000);
      failures++;
      final_report();
   end

   // ****************
   // Main sequence
   // ****************
   initial begin
      void'($urandom(85987));
      do_reset();
      // Every mode code in every field, then random accesses with unmapped ones
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_P3_LOW_MODES, {4{2'(c)}});
         wr(ADDR_P3_HIGH_MODES, {4{2'(c)}});
         wr(ADDR_P1_BIT4_MODE, 8'(c));
         chk_state();
      end
      repeat (40) begin
         a = ($urandom % 2) ? ADDR_P1_BIT4_MODE + 8'($urandom % 5) : 8'($urandom);
         d = 8'($urandom);
         wr(a, d);
         chk_state();
         rdchk(a);
      end
      wr(ADDR_ALT_ROUTING, 8'h00);
      wr(ADDR_ALT_ROUTING, 8'h20);
      repeat (4) @(negedge sys_clk_i);
      prev = p1_pin_o[PIN_HALF_CLK];
      repeat (8) begin
         @(negedge sys_clk_i);
         chk("half_clock", {15'h0, ~prev}, {15'h0, p1_pin_o[PIN_HALF_CLK]});
         prev = p1_pin_o[PIN_HALF_CLK];
      end
      wr(ADDR_ALT_ROUTING, 8'h10);
      for (int i = 1; i < 5; i++) begin
         pulses(1, 1'b0);
         chk("t2_out", 16'(i % 2), {15'h0, p1_pin_o[PIN_T2]});
      end
      pulses(1, 1'b0);
      wr(ADDR_ALT_ROUTING, 8'h00);
      wr(ADDR_ALT_ROUTING, 8'h11);
      repeat (3) @(negedge sys_clk_i);
      chk("t2_cleared", 16'h0000, {15'h0, p1_pin_o[PIN_T2]});
      for (int i = 0; i < 4; i++) begin
         pulses(i % 2 ? 1 : 31, 1'b1);
         chk("t0_out", 16'(i == 1 || i == 2), {15'h0, p3_pin_o[PIN_T0]});
      end
      do_reset();
      final_report();
   end
endmodule
